// ===== hdl/bfc_map.vh
// Purpose: Constants for the branch and flow control unit.
// Assumes: Opcodes are produced by the core's instruction decoder.
// Notes:   Cycle counts are whole core clocks.
`ifndef BFC_MAP_VH
`define BFC_MAP_VH

// ****************************************
// Operation codes
// ****************************************
`define BFC_OP_W 5
`define BFC_OP_POINTER_JUMP 5'h00
`define BFC_OP_ABSOLUTE_JUMP 5'h01
`define BFC_OP_RELATIVE_SUBROUTINE_ENTRY 5'h02
`define BFC_OP_POINTER_SUBROUTINE_ENTRY 5'h03
`define BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY 5'h04
`define BFC_OP_SUBROUTINE_EXIT 5'h05
`define BFC_OP_INTERRUPT_EXIT 5'h06
`define BFC_OP_COMPARE_SKIP_EQUAL 5'h07
`define BFC_OP_COMPARE_REGISTERS 5'h08
`define BFC_OP_COMPARE_WITH_BORROW 5'h09
`define BFC_OP_COMPARE_IMMEDIATE 5'h0A
`define BFC_OP_SKIP_REG_BIT_CLEAR 5'h0B
`define BFC_OP_SKIP_REG_BIT_SET 5'h0C
`define BFC_OP_SKIP_IO_BIT_CLEAR 5'h0D
`define BFC_OP_SKIP_IO_BIT_SET 5'h0E
`define BFC_OP_BRANCH_STATUS_BIT_SET 5'h0F
`define BFC_OP_BRANCH_STATUS_BIT_CLEAR 5'h10
`define BFC_OP_BRANCH_EQUAL 5'h11
`define BFC_OP_BRANCH_NOT_EQUAL 5'h12
`define BFC_OP_BRANCH_CARRY_SET 5'h13
`define BFC_OP_BRANCH_CARRY_CLEAR 5'h14
`define BFC_OP_BRANCH_SAME_OR_HIGHER 5'h15
`define BFC_OP_BRANCH_LOWER 5'h16
`define BFC_OP_BRANCH_MINUS 5'h17
`define BFC_OP_BRANCH_PLUS 5'h18
`define BFC_OP_BRANCH_GREATER_EQUAL_SIGNED 5'h19
`define BFC_OP_BRANCH_LESS_SIGNED 5'h1A
`define BFC_OP_BRANCH_HALF_CARRY_SET 5'h1B
`define BFC_OP_BRANCH_HALF_CARRY_CLEAR 5'h1C
`define BFC_OP_BRANCH_TRANSFER_BIT_SET 5'h1D

// ****************************************
// Status register bit positions
// ****************************************
`define BFC_SR_CARRY 0
`define BFC_SR_ZERO 1
`define BFC_SR_NEGATIVE 2
`define BFC_SR_OVERFLOW 3
`define BFC_SR_SIGN 4
`define BFC_SR_HALF_CARRY 5
`define BFC_SR_TRANSFER 6
`define BFC_SR_INT_ENABLE 7

// ****************************************
// Cycle costs
// ****************************************
`define BFC_CYC_W 3
`define BFC_CYC_SINGLE 3'h1
`define BFC_CYC_POINTER_JUMP 3'h2
`define BFC_CYC_ABSOLUTE_JUMP 3'h3
`define BFC_CYC_SHORT_ENTRY 3'h3
`define BFC_CYC_ABSOLUTE_ENTRY 3'h4
`define BFC_CYC_EXIT 3'h4
`define BFC_CYC_BRANCH_TAKEN 3'h2
`define BFC_CYC_SKIP_ONE_WORD 3'h2
`define BFC_CYC_SKIP_TWO_WORD 3'h3

`endif

// ===== hdl/bfc_cond.v
// Purpose: Compare arithmetic and condition evaluation for flow control.
// Assumes: All inputs are stable in the cycle the operation is accepted.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`include "bfc_map.vh"

module bfc_cond (
    input wire [4:0] op,            // Operation code
    input wire [7:0] rd_value,      // First general register operand
    input wire [7:0] rr_value,      // Second general register operand
    input wire [7:0] imm_value,     // Immediate operand
    input wire [2:0] bit_sel,       // Selected bit number
    input wire [7:0] io_value,      // Selected I/O register contents
    input wire [7:0] status_in,     // Current status register
    output reg cond_true,           // Skip or branch condition holds
    output reg [7:0] status_cmp     // Status register after a compare
);

    // ****************************************
    // Compare difference
    // ****************************************
    wire use_imm = (op == `BFC_OP_COMPARE_IMMEDIATE);
    wire use_borrow = (op == `BFC_OP_COMPARE_WITH_BORROW);
    wire [7:0] rhs = use_imm ? imm_value : rr_value;
    wire borrow_in = use_borrow & status_in[`BFC_SR_CARRY];
    wire [8:0] diff = {1'b0, rd_value} - {1'b0, rhs} - {8'h00, borrow_in};
    wire [7:0] res = diff[7:0];
    wire half = (~rd_value[3] & rhs[3]) | (rhs[3] & res[3]) | (res[3] & ~rd_value[3]);
    wire ovf = (rd_value[7] & ~rhs[7] & ~res[7]) | (~rd_value[7] & rhs[7] & res[7]);
    // With borrow the zero flag only stays set, so multi-byte compares chain
    wire zero = (res == 8'h00) & (~use_borrow | status_in[`BFC_SR_ZERO]);

    always @* begin
        status_cmp = status_in;
        status_cmp[`BFC_SR_CARRY] = diff[8];
        status_cmp[`BFC_SR_ZERO] = zero;
        status_cmp[`BFC_SR_NEGATIVE] = res[7];
        status_cmp[`BFC_SR_OVERFLOW] = ovf;
        status_cmp[`BFC_SR_HALF_CARRY] = half;
    end

    // ****************************************
    // Conditions
    // ****************************************
    wire fc = status_in[`BFC_SR_CARRY];
    wire fz = status_in[`BFC_SR_ZERO];
    wire fn = status_in[`BFC_SR_NEGATIVE];
    wire fv = status_in[`BFC_SR_OVERFLOW];
    wire fh = status_in[`BFC_SR_HALF_CARRY];
    wire ft = status_in[`BFC_SR_TRANSFER];

    always @* begin
        case (op)
            `BFC_OP_COMPARE_SKIP_EQUAL: cond_true = (rd_value == rr_value);
            `BFC_OP_SKIP_REG_BIT_CLEAR: cond_true = ~rr_value[bit_sel];
            `BFC_OP_SKIP_REG_BIT_SET: cond_true = rr_value[bit_sel];
            `BFC_OP_SKIP_IO_BIT_CLEAR: cond_true = ~io_value[bit_sel];
            `BFC_OP_SKIP_IO_BIT_SET: cond_true = io_value[bit_sel];
            `BFC_OP_BRANCH_STATUS_BIT_SET: cond_true = status_in[bit_sel];
            `BFC_OP_BRANCH_STATUS_BIT_CLEAR: cond_true = ~status_in[bit_sel];
            `BFC_OP_BRANCH_EQUAL: cond_true = fz;
            `BFC_OP_BRANCH_NOT_EQUAL: cond_true = ~fz;
            `BFC_OP_BRANCH_MINUS: cond_true = fn;
            `BFC_OP_BRANCH_PLUS: cond_true = ~fn;
            `BFC_OP_BRANCH_CARRY_SET: cond_true = fc;
            `BFC_OP_BRANCH_LOWER: cond_true = fc;
            `BFC_OP_BRANCH_CARRY_CLEAR: cond_true = ~fc;
            `BFC_OP_BRANCH_SAME_OR_HIGHER: cond_true = ~fc;
            `BFC_OP_BRANCH_GREATER_EQUAL_SIGNED: cond_true = ~(fn ^ fv);
            `BFC_OP_BRANCH_LESS_SIGNED: cond_true = fn ^ fv;
            `BFC_OP_BRANCH_HALF_CARRY_SET: cond_true = fh;
            `BFC_OP_BRANCH_HALF_CARRY_CLEAR: cond_true = ~fh;
            `BFC_OP_BRANCH_TRANSFER_BIT_SET: cond_true = ft;
            default: cond_true = 1'b0;
        endcase
    end

endmodule // bfc_cond

// ===== hdl/bfc_unit.v
// Purpose: Branch and flow control unit of an 8-bit core.
// Assumes: Decoder supplies opcode and operands for one cycle with instr_valid.
// Notes:   next_pc is the program counter after the instruction in every case.
//
// Function
// - Pointer jump 2 cycles; absolute jump 3.
// - Entries push return; relative/pointer 3, absolute 4.
// - Compare-skip on equal; 1, 2 or 3 cycles.
// - Compares set five flags, write nothing, 1 cycle.
// - Register bit skips on clear/set, flags untouched.
// - I/O bit skips on clear/set, flags untouched.
// - Status bit branches; 1 not taken, 2 taken.
// - Carry branches to PC+k+1; 1 or 2 cycles.
// - Signed branches test negative XOR overflow.
// - Half-carry branches set/clear; 1 or 2 cycles.
// - Transfer-bit branch when set; 1 or 2 cycles.
`timescale 1ns/1ps
`include "bfc_map.vh"

module bfc_unit #(
    parameter PC_W = 16,            // Program counter width in words
    parameter OFS_W = 12            // Width of sign-extended relative offset
) (
    input wire clk,                     // Core clock
    input wire rst_n,                   // Synchronous reset, active low
    input wire instr_valid,             // Decoded instruction offered
    input wire [4:0] instr_op,          // Operation code
    input wire [PC_W-1:0] instr_pc,     // Address of the offered instruction
    input wire [OFS_W-1:0] rel_offset,  // Signed relative offset k
    input wire [PC_W-1:0] abs_target,   // Encoded absolute target
    input wire [PC_W-1:0] ptr_value,    // Pointer register pair value
    input wire [7:0] rd_value,          // First register operand
    input wire [7:0] rr_value,          // Second register operand
    input wire [7:0] imm_value,         // Immediate operand
    input wire [2:0] bit_sel,           // Bit number of a test
    input wire [7:0] io_value,          // Selected I/O register
    input wire [7:0] status_in,         // Current status register
    input wire next_two_word,           // Following instruction is two words
    input wire [PC_W-1:0] stack_ret,    // Return address popped from stack
    output reg instr_ready,             // Unit can take an instruction
    output reg done,                    // Instruction finished, next_pc valid
    output reg [PC_W-1:0] next_pc,      // Program counter to continue from
    output reg push_req,                // Push return address
    output reg [PC_W-1:0] push_addr,    // Return address to push
    output reg pop_req,                 // Pop return address
    output reg status_we,               // Write status_out to status register
    output reg [7:0] status_out         // New status register value
);

    // ****************************************
    // States and locals
    // ****************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [1:0] state;
    reg [2:0] cnt;
    reg [PC_W-1:0] pc_hold;
    reg hold_exit;
    reg hold_int_exit;

    reg [2:0] next_cost;
    reg [PC_W-1:0] next_target;

    wire cond_true;
    wire [7:0] status_cmp;
    wire accept = instr_valid & instr_ready;

    wire [PC_W-1:0] pc_plus1 = instr_pc + {{(PC_W-1){1'b0}}, 1'b1};
    wire [PC_W-1:0] pc_plus2 = instr_pc + {{(PC_W-2){1'b0}}, 2'b10};
    wire [PC_W-1:0] pc_plus3 = instr_pc + {{(PC_W-2){1'b0}}, 2'b11};
    wire [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){rel_offset[OFS_W-1]}}, rel_offset};
    wire [PC_W-1:0] pc_rel = pc_plus1 + ofs_ext;

    // ****************************************
    // Decode helpers
    // ****************************************
    function is_flag_branch;
        input [4:0] op;
        begin
            is_flag_branch = (op >= `BFC_OP_BRANCH_STATUS_BIT_SET) &&
                (op <= `BFC_OP_BRANCH_TRANSFER_BIT_SET);
        end
    endfunction

    function is_skip;
        input [4:0] op;
        begin
            is_skip = (op == `BFC_OP_COMPARE_SKIP_EQUAL) ||
                ((op >= `BFC_OP_SKIP_REG_BIT_CLEAR) && (op <= `BFC_OP_SKIP_IO_BIT_SET));
        end
    endfunction

    function is_compare;
        input [4:0] op;
        begin
            is_compare = (op >= `BFC_OP_COMPARE_REGISTERS) &&
                (op <= `BFC_OP_COMPARE_IMMEDIATE);
        end
    endfunction

    function is_entry;
        input [4:0] op;
        begin
            is_entry = (op >= `BFC_OP_RELATIVE_SUBROUTINE_ENTRY) &&
                (op <= `BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY);
        end
    endfunction

    function is_exit;
        input [4:0] op;
        begin
            is_exit = (op == `BFC_OP_SUBROUTINE_EXIT) || (op == `BFC_OP_INTERRUPT_EXIT);
        end
    endfunction

    // ****************************************
    // Condition and compare logic
    // ****************************************
    bfc_cond u_cond (
        .op(instr_op),
        .rd_value(rd_value),
        .rr_value(rr_value),
        .imm_value(imm_value),
        .bit_sel(bit_sel),
        .io_value(io_value),
        .status_in(status_in),
        .cond_true(cond_true),
        .status_cmp(status_cmp)
    );

    // ****************************************
    // Cost and target of the offered instruction
    // ****************************************
    always @* begin
        next_cost = `BFC_CYC_SINGLE;
        next_target = pc_plus1;
        case (instr_op)
            `BFC_OP_POINTER_JUMP: begin
                next_cost = `BFC_CYC_POINTER_JUMP;
                next_target = ptr_value;
            end
            `BFC_OP_ABSOLUTE_JUMP: begin
                next_cost = `BFC_CYC_ABSOLUTE_JUMP;
                next_target = abs_target;
            end
            `BFC_OP_RELATIVE_SUBROUTINE_ENTRY: begin
                next_cost = `BFC_CYC_SHORT_ENTRY;
                next_target = pc_rel;
            end
            `BFC_OP_POINTER_SUBROUTINE_ENTRY: begin
                next_cost = `BFC_CYC_SHORT_ENTRY;
                next_target = ptr_value;
            end
            `BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY: begin
                next_cost = `BFC_CYC_ABSOLUTE_ENTRY;
                next_target = abs_target;
            end
            `BFC_OP_SUBROUTINE_EXIT,
            `BFC_OP_INTERRUPT_EXIT: begin
                next_cost = `BFC_CYC_EXIT;
            end
            default: begin
                // Skips step over one or two words; costs follow that length
                if (is_skip(instr_op) && cond_true) begin
                    next_cost = next_two_word ? `BFC_CYC_SKIP_TWO_WORD :
                        `BFC_CYC_SKIP_ONE_WORD;
                    next_target = next_two_word ? pc_plus3 : pc_plus2;
                end else if (is_flag_branch(instr_op) && cond_true) begin
                    next_cost = `BFC_CYC_BRANCH_TAKEN;
                    next_target = pc_rel;
                end
            end
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= 3'h0;
            pc_hold <= {PC_W{1'b0}};
            hold_exit <= 1'b0;
            hold_int_exit <= 1'b0;
            instr_ready <= 1'b0;
            done <= 1'b0;
            next_pc <= {PC_W{1'b0}};
            push_req <= 1'b0;
            push_addr <= {PC_W{1'b0}};
            pop_req <= 1'b0;
            status_we <= 1'b0;
            status_out <= 8'h00;
        end else begin
            done <= 1'b0;
            push_req <= 1'b0;
            pop_req <= 1'b0;
            status_we <= 1'b0;
            case (state)
                ST_IDLE: begin
                    instr_ready <= 1'b1;
                    if (accept) begin
                        // Absolute entry is two words long, so it returns past both
                        if (is_entry(instr_op)) begin
                            push_req <= 1'b1;
                            push_addr <= (instr_op == `BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY) ?
                                pc_plus2 : pc_plus1;
                        end
                        pop_req <= is_exit(instr_op);
                        hold_exit <= is_exit(instr_op);
                        hold_int_exit <= (instr_op == `BFC_OP_INTERRUPT_EXIT);
                        // Compares touch flags here, interrupt exit at its end; skips and branches leave them
                        if (is_compare(instr_op)) begin
                            status_we <= 1'b1;
                            status_out <= status_cmp;
                        end
                        if (next_cost == `BFC_CYC_SINGLE) begin
                            done <= 1'b1;
                            next_pc <= next_target;
                        end else begin
                            state <= ST_RUN;
                            instr_ready <= 1'b0;
                            cnt <= next_cost - `BFC_CYC_SINGLE;
                            pc_hold <= next_target;
                        end
                    end
                end
                ST_RUN: begin
                    cnt <= cnt - 3'h1;
                    if (cnt == 3'h1) begin
                        done <= 1'b1;
                        state <= ST_IDLE;
                        instr_ready <= 1'b1;
                        // Stack data is taken at the last edge to give the pop time
                        next_pc <= hold_exit ? stack_ret : pc_hold;
                        if (hold_int_exit) begin
                            status_we <= 1'b1;
                            status_out <= status_in | (8'h01 << `BFC_SR_INT_ENABLE);
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    instr_ready <= 1'b0;
                end
            endcase
        end
    end

endmodule // bfc_unit

// ===== sim/bfc_stack_model.sv
// Purpose: Return stack seen by the flow control unit.
// Assumes: Pushes and pops are one-cycle strobes; depth 8 is ample here.
// Notes:   A stale popped value toggles so a late sample is caught.
`timescale 1ns/1ps

module bfc_stack_model (
    input wire clk, // Core clock
    input wire rst_n, // Reset, active low
    input wire push_req, // Push strobe
    input wire [15:0] push_addr, // Address pushed
    input wire pop_req, // Pop strobe
    output reg [15:0] stack_ret // Popped address
);
    reg [15:0] mem [0:7];
    reg [2:0] sp;
    reg [2:0] age;
    always @(posedge clk) begin
        if (!rst_n) begin
            sp <= 3'h0;
            age <= 3'h0;
            stack_ret <= 16'h0000;
        end else if (push_req) begin
            mem[sp] <= push_addr;
            sp <= sp + 3'h1;
        end else if (pop_req) begin
            stack_ret <= mem[sp - 3'h1];
            sp <= sp - 3'h1;
            age <= 3'h4;
        end else if (age != 3'h0) begin
            age <= age - 3'h1;
        end else begin
            // Hold time is over: never let an old value look valid
            stack_ret <= ~stack_ret;
        end
    end
endmodule // bfc_stack_model

// ===== sim/bfc_unit_asserts.sv
// Purpose: Port timing checks on the flow control unit.
// Assumes: Single clock, synchronous reset.
// Notes:   Branch conditions are judged by the testbench.
`timescale 1ns/1ps
`include "bfc_map.vh"

module bfc_unit_asserts #(
    parameter PC_W = 16, // Program counter width
    parameter OFS_W = 12 // Offset width
) (
    input wire clk, // Clock
    input wire rst_n, // Reset
    input wire instr_valid, // Offer
    input wire [4:0] instr_op, // Opcode
    input wire [PC_W-1:0] instr_pc, // Address
    input wire [OFS_W-1:0] rel_offset, // Offset
    input wire [PC_W-1:0] abs_target, // Target
    input wire [PC_W-1:0] ptr_value, // Pointer
    input wire [7:0] status_in, // Status
    input wire [PC_W-1:0] stack_ret, // Popped
    input wire instr_ready, // Ready
    input wire done, // Done
    input wire [PC_W-1:0] next_pc, // Next
    input wire push_req, // Push
    input wire [PC_W-1:0] push_addr, // Pushed
    input wire pop_req, // Pop
    input wire status_we, // Flag write
    input wire [7:0] status_out // Flags
);
    wire acc = instr_valid && instr_ready;
    wire [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){rel_offset[OFS_W-1]}}, rel_offset};
    // Held at PC width so address wrap matches the unit
    wire [PC_W-1:0] pc1 = instr_pc + PC_W'(1);
    wire [PC_W-1:0] pc2 = instr_pc + PC_W'(2);
    wire [PC_W-1:0] rel_tgt = pc1 + ofs_ext;
    wire is_cmp = instr_op == `BFC_OP_COMPARE_REGISTERS
        || instr_op == `BFC_OP_COMPARE_WITH_BORROW || instr_op == `BFC_OP_COMPARE_IMMEDIATE;
    wire int_op = instr_op == `BFC_OP_INTERRUPT_EXIT;
    wire any_exit = int_op || instr_op == `BFC_OP_SUBROUTINE_EXIT;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_compare_one_cycle: assert property (acc && is_cmp |=> done && status_we)
        else $error("compare not done with flags in one cycle");
    a_pointer_jump_two: assert property (acc && instr_op == `BFC_OP_POINTER_JUMP
        |=> !done ##1 done && next_pc == $past(ptr_value, 2))
        else $error("pointer jump wrong");
    a_abs_jump_three: assert property (acc && instr_op == `BFC_OP_ABSOLUTE_JUMP
        |=> !done [*2] ##1 done && next_pc == $past(abs_target, 3))
        else $error("absolute jump wrong");
    a_abs_entry_four: assert property (acc && instr_op == `BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY
        |=> push_req && push_addr == $past(pc2) ##1 !done [*2] ##1 done
        && next_pc == $past(abs_target, 4))
        else $error("absolute entry wrong");
    a_rel_entry_three: assert property (acc
        && instr_op == `BFC_OP_RELATIVE_SUBROUTINE_ENTRY
        |=> push_req && push_addr == $past(pc1) ##2 done && next_pc == $past(rel_tgt, 3))
        else $error("relative entry wrong");
    a_exit_pop_four: assert property (acc && any_exit
        |=> pop_req ##3 done && next_pc == $past(stack_ret))
        else $error("exit did not restore counter");
    a_exit_sets_enable: assert property (acc && int_op
        |-> ##4 status_we && status_out == ($past(status_in) | 8'h80))
        else $error("interrupt exit did not set enable");
    a_flags_source_only: assert property (status_we
        |-> $past(acc && is_cmp) || $past(acc && int_op, 4))
        else $error("flags written by wrong operation");
    a_ready_busy_entry: assert property (acc
        && instr_op == `BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY |=> !instr_ready [*3] ##1 instr_ready)
        else $error("ready wrong during entry");
    c_compare: cover property (acc && is_cmp);
    c_pop: cover property (pop_req ##3 done);
    c_push: cover property (push_req ##3 done);
endmodule // bfc_unit_asserts

bind bfc_unit bfc_unit_asserts #(.PC_W(PC_W), .OFS_W(OFS_W)) i_chk (.clk, .rst_n,
    .instr_valid, .instr_op, .instr_pc, .rel_offset, .abs_target, .ptr_value, .status_in,
    .stack_ret, .instr_ready, .done, .next_pc, .push_req, .push_addr, .pop_req,
    .status_we, .status_out);

// ===== sim/bfc_unit_tb_top.sv
// Purpose: Self-checking bench for the flow control unit.
// Assumes: Inputs change on the falling edge; one idle cycle between ops.
// Notes:   One op at a time keeps the driver simple.
`timescale 1ns/1ps
`include "bfc_map.vh"

module bfc_unit_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg instr_valid = 1'b0;
    reg [4:0] instr_op = 5'h00;
    reg [15:0] instr_pc = 16'h0000;
    reg [11:0] rel_offset = 12'h000;
    reg [15:0] abs_target = 16'h0000;
    reg [15:0] ptr_value = 16'h0000;
    reg [7:0] rd_value = 8'h00;
    reg [7:0] rr_value = 8'h00;
    reg [7:0] imm_value = 8'h00;
    reg [2:0] bit_sel = 3'h0;
    reg [7:0] io_value = 8'h00;
    reg [7:0] status_in = 8'h00;
    reg next_two_word = 1'b0;
    wire [15:0] stack_ret, next_pc, push_addr;
    wire instr_ready, done, push_req, pop_req, status_we;
    wire [7:0] status_out;
    integer bad_count = 0;
    integer cmp_count = 0;
    integer i, op;
    reg [15:0] got_cost;
    reg t;

    always #10 clk = ~clk;

    bfc_unit i_dut (.clk, .rst_n, .instr_valid, .instr_op, .instr_pc, .rel_offset,
        .abs_target, .ptr_value, .rd_value, .rr_value, .imm_value, .bit_sel, .io_value,
        .status_in, .next_two_word, .stack_ret, .instr_ready, .done, .next_pc, .push_req,
        .push_addr, .pop_req, .status_we, .status_out);
    bfc_stack_model i_stack (.clk, .rst_n, .push_req, .push_addr, .pop_req, .stack_ret);

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Issue one op, count cycles to done, then compare cost and next_pc
    task expect_op(input [4:0] opc, input [15:0] cost, input [15:0] pc);
        begin
            do @(negedge clk); while (instr_ready !== 1'b1);
            instr_op = opc;
            instr_valid = 1'b1;
            @(negedge clk);
            instr_valid = 1'b0;
            got_cost = 16'h0001;
            while (done !== 1'b1 && got_cost < 16'h0008) begin
                @(negedge clk);
                got_cost = got_cost + 16'h0001;
            end
            check(got_cost, cost);
            check(next_pc, pc);
        end
    endtask
    function tk(input [4:0] o, input [7:0] s);
        begin
            // Flag positions: C0 Z1 N2 V3 H5 T6
            case (o)
                `BFC_OP_BRANCH_STATUS_BIT_SET: tk = s[bit_sel];
                `BFC_OP_BRANCH_STATUS_BIT_CLEAR: tk = !s[bit_sel];
                `BFC_OP_BRANCH_EQUAL: tk = s[1];
                `BFC_OP_BRANCH_NOT_EQUAL: tk = !s[1];
                `BFC_OP_BRANCH_CARRY_SET, `BFC_OP_BRANCH_LOWER: tk = s[0];
                `BFC_OP_BRANCH_CARRY_CLEAR, `BFC_OP_BRANCH_SAME_OR_HIGHER: tk = !s[0];
                `BFC_OP_BRANCH_MINUS: tk = s[2];
                `BFC_OP_BRANCH_PLUS: tk = !s[2];
                `BFC_OP_BRANCH_GREATER_EQUAL_SIGNED: tk = !(s[2] ^ s[3]);
                `BFC_OP_BRANCH_LESS_SIGNED: tk = s[2] ^ s[3];
                `BFC_OP_BRANCH_HALF_CARRY_SET: tk = s[5];
                `BFC_OP_BRANCH_HALF_CARRY_CLEAR: tk = !s[5];
                `BFC_OP_BRANCH_TRANSFER_BIT_SET: tk = s[6];
                default: tk = 1'b0;
            endcase
        end
    endfunction
    task cmp_case(input [4:0] o, input [7:0] a, input [7:0] b, input [7:0] s,
        input [7:0] exp);
        begin
            rd_value = a;
            rr_value = b;
            imm_value = b;
            status_in = s;
            expect_op(o, 16'h0001, 16'h0041);
            check({8'h00, status_out}, {8'h00, exp});
        end
    endtask
    task skip_case(input [4:0] o, input two, input [15:0] cost);
        begin
            next_two_word = two;
            expect_op(o, cost, 16'h0200 + cost);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_jumps;
        begin
            ptr_value = 16'h1234;
            abs_target = 16'h0ABC;
            expect_op(`BFC_OP_POINTER_JUMP, 16'h0002, 16'h1234);
            expect_op(`BFC_OP_ABSOLUTE_JUMP, 16'h0003, 16'h0ABC);
        end
    endtask
    task t_calls;
        begin
            instr_pc = 16'h0100;
            abs_target = 16'h2000;
            expect_op(`BFC_OP_ABSOLUTE_SUBROUTINE_ENTRY, 16'h0004, 16'h2000);
            instr_pc = 16'h2000;
            rel_offset = 12'hFF0;
            expect_op(`BFC_OP_RELATIVE_SUBROUTINE_ENTRY, 16'h0003, 16'h1FF1);
            instr_pc = 16'h1FF1;
            ptr_value = 16'h3000;
            expect_op(`BFC_OP_POINTER_SUBROUTINE_ENTRY, 16'h0003, 16'h3000);
            expect_op(`BFC_OP_SUBROUTINE_EXIT, 16'h0004, 16'h1FF2);
            expect_op(`BFC_OP_SUBROUTINE_EXIT, 16'h0004, 16'h2001);
            status_in = 8'h15;
            expect_op(`BFC_OP_INTERRUPT_EXIT, 16'h0004, 16'h0102);
            check({8'h00, status_out}, 16'h0095);
        end
    endtask
    task t_compare;
        begin
            instr_pc = 16'h0040;
            cmp_case(`BFC_OP_COMPARE_REGISTERS, 8'h10, 8'h20, 8'hC0, 8'hC5);
            cmp_case(`BFC_OP_COMPARE_REGISTERS, 8'h05, 8'h05, 8'h00, 8'h02);
            cmp_case(`BFC_OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'h00, 8'h28);
            cmp_case(`BFC_OP_COMPARE_WITH_BORROW, 8'h05, 8'h04, 8'h03, 8'h02);
            cmp_case(`BFC_OP_COMPARE_WITH_BORROW, 8'h05, 8'h04, 8'h11, 8'h10);
        end
    endtask
    task t_skips;
        begin
            instr_pc = 16'h0200;
            rd_value = 8'h04;
            rr_value = 8'h04;
            io_value = 8'hFB;
            bit_sel = 3'h2;
            skip_case(`BFC_OP_COMPARE_SKIP_EQUAL, 1'b0, 16'h0002);
            skip_case(`BFC_OP_COMPARE_SKIP_EQUAL, 1'b1, 16'h0003);
            skip_case(`BFC_OP_SKIP_REG_BIT_CLEAR, 1'b1, 16'h0001);
            skip_case(`BFC_OP_SKIP_REG_BIT_SET, 1'b1, 16'h0003);
            skip_case(`BFC_OP_SKIP_IO_BIT_CLEAR, 1'b0, 16'h0002);
            skip_case(`BFC_OP_SKIP_IO_BIT_SET, 1'b0, 16'h0001);
            rd_value = 8'h05;
            bit_sel = 3'h3;
            skip_case(`BFC_OP_COMPARE_SKIP_EQUAL, 1'b1, 16'h0001);
            skip_case(`BFC_OP_SKIP_REG_BIT_CLEAR, 1'b0, 16'h0002);
            skip_case(`BFC_OP_SKIP_IO_BIT_SET, 1'b1, 16'h0003);
        end
    endtask
    // Every branch code under four flag patterns, plus an unused code
    task t_branches;
        begin
            instr_pc = 16'h0300;
            rel_offset = 12'h010;
            for (i = 0; i < 4; i = i + 1) begin
                status_in = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h04 : 8'h0C;
                bit_sel = i[2:0];
                for (op = 15; op < 31; op = op + 1) begin
                    t = tk(op[4:0], status_in);
                    expect_op(op[4:0], t ? 16'h0002 : 16'h0001,
                        t ? 16'h0311 : 16'h0301);
                end
            end
        end
    endtask

    task results;
        begin
            $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        repeat (10) @(negedge clk);
        check({15'h0000, instr_ready}, 16'h0000);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_jumps;
        t_calls;
        t_compare;
        t_skips;
        t_branches;
        results;
    end
    initial begin
        #200000;
        bad_count = bad_count + 1;
        results;
    end
endmodule // bfc_unit_tb_top
